/* File: serial_host_register_port.sv */
// Four-wire serial host register port with APB status and control
//
// Overview of operation
// RULE1 - Four wires: data in, out, select, clock
// RULE2 - Port works only while select strap low
// RULE3 - Serial out is unregistered copy of in
// RULE4 - Host opens each access with command word
// RULE5 - Data word follows command, direction by flag
// RULE6 - Command sent MSB first, flags plus address
// RULE7 - Command bits sampled on serial clock rise
// RULE8 - Without increment, host sends one data word
// RULE9 - With increment, each word targets next address
// RULE10 - Increment applies to reads and writes
// RULE11 - Host selects one device for reads
// RULE12 - Writes pass all bits through unchanged
// RULE13 - Every selected chained device accepts writes
// RULE14 - Host alone starts and ends accesses
// RULE15 - Write word gap at least 37.1 ns
// RULE16 - Read gap 148.4 ns, 222.6 with ancillary
// RULE17 - Select held 37.1 ns after last clock
// RULE18 - Select low before first clock rise
// RULE19 - Every register individually addressable
// RULE20 - Strap high hands pins to test port
// RULE21 - Bit15 read, bit12 increment, bits11:0 address
// RULE22 - Data MSB first, read drives serial out
// RULE23 - Host signals synchronised into core clock
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "serial_port_regs.svh"
module serial_host_register_port #(
  parameter int DEPTH = 64
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        sclk, // see RULE1
  input  wire logic        cs_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  input  wire logic        if_select,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////////////
  // Gap figures in core clock cycles, rounded up

  localparam int WR_GAP_CYC  = (`WR_GAP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam int RD_GAP_CYC  = (`RD_GAP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;
  localparam int ANC_GAP_CYC = (`ANC_RD_GAP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS;

  serial_port_pkg::port_regs_t st;
  serial_port_pkg::port_regs_t next_st;

  logic [3:0]  sync_q;
  logic        sclk_s;
  logic        cs_n_s;
  logic        sin_s;
  logic        strap_s;
  logic        rise;
  logic        fall;
  logic [15:0] word_in;
  logic        cmd_done;
  logic        data_done;
  logic [7:0]  gap_need;
  logic        apb_access;

  reg_store_if mem ();

  ////////////////////////////////////////////////////////////////////////////////
  // Host pins pass two flip-flops before the sequencer uses them

  bit_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in ({if_select, serial_in, ~cs_n, sclk}), // Select inverted: reset reads as idle
    .sync_out (sync_q)
  ); // see RULE23

  assign sclk_s  = sync_q[0];
  assign cs_n_s  = !sync_q[1];
  assign sin_s   = sync_q[2];
  assign strap_s = sync_q[3];

  // Edges of the burst clock seen in the core domain
  assign rise      = sclk_s && !st.sclk_prev; // see RULE7
  assign fall      = !sclk_s && st.sclk_prev;
  assign word_in   = {st.in_shift[14:0], sin_s}; // see RULE6
  assign cmd_done  = (st.state == serial_port_pkg::ST_CMD) && rise && (st.bit_cnt == 4'hf);
  assign data_done = (st.state == serial_port_pkg::ST_DATA) && rise && (st.bit_cnt == 4'hf);
  assign apb_access = psel && penable && !st.pready;

  // Least gap before the next data word, by direction and ancillary mode
  always_comb
  begin
    if (!st.cmd_read)
      gap_need = 8'(WR_GAP_CYC); // see RULE15
    else if (st.anc_readback && st.anc_insert)
      gap_need = 8'(ANC_GAP_CYC); // see RULE16
    else
      gap_need = 8'(RD_GAP_CYC);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register store

  reg_store #(
    .DEPTH (DEPTH)
  ) u_store (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .bus     (mem.store)
  ); // see RULE19

  // Store requests come from registered state
  assign mem.rd_en = st.rd_req;
  assign mem.wr_en = st.wr_req;
  assign mem.addr  = st.mem_addr;
  assign mem.wdata = st.wr_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: APB slave first, serial sequencer after so its flags win

  always_comb
  begin
    next_st              = st;
    next_st.sclk_prev    = sclk_s;
    next_st.rd_req       = 1'b0;
    next_st.wr_req       = 1'b0;
    next_st.load_pending = st.rd_req;
    next_st.pready       = 1'b0;
    next_st.pslverr      = 1'b0;

    // APB access phase answered one cycle later
    if (apb_access)
    begin
      next_st.pready = 1'b1;
      next_st.prdata = 32'h0000_0000;
      unique case (paddr)
        `OFS_CTRL:
        begin
          next_st.prdata[`CTRL_ANC_READBACK] = st.anc_readback;
          next_st.prdata[`CTRL_ANC_INSERT]   = st.anc_insert;
        end
        `OFS_STATUS:
        begin
          next_st.prdata[`STAT_BUSY]       = (st.state != serial_port_pkg::ST_IDLE);
          next_st.prdata[`STAT_TEST_MODE]  = strap_s;
          next_st.prdata[`STAT_GAP_VIOL]   = st.gap_viol;
          next_st.prdata[`STAT_READ_DRIVE] = st.rd_drive;
        end
        `OFS_LAST_CMD:
          next_st.prdata[15:0] = st.last_cmd;
        `OFS_WORD_COUNT:
          next_st.prdata[15:0] = st.word_cnt;
        default:
          next_st.pslverr = 1'b1;
      endcase
    end

    // Writes land at the edge where pready is seen high, ending the transfer
    if (psel && penable && pwrite && st.pready)
    begin
      unique case (paddr)
        `OFS_CTRL:
        begin
          next_st.anc_readback = pwdata[`CTRL_ANC_READBACK];
          next_st.anc_insert   = pwdata[`CTRL_ANC_INSERT];
        end
        `OFS_STATUS:
          if (pwdata[`STAT_GAP_VIOL])
            next_st.gap_viol = 1'b0;
        `OFS_WORD_COUNT:
          next_st.word_cnt = 16'h0000;
        default:
          ; // Read-only and unmapped words ignore writes
      endcase
    end

    // Read data arrives one cycle after the store request
    if (st.load_pending)
      next_st.out_shift = mem.rdata;
    if (st.gap_cnt != 8'hff)
      next_st.gap_cnt = st.gap_cnt + 8'h01;

    // Deselect or test-port strap parks the sequencer
    if (strap_s || cs_n_s)
    begin
      next_st.state    = serial_port_pkg::ST_IDLE; // see RULE2
      next_st.rd_drive = 1'b0;
      next_st.bit_cnt  = 4'h0;
    end
    else
    begin
      unique case (st.state)
        serial_port_pkg::ST_IDLE:
          next_st.state = serial_port_pkg::ST_CMD;
        serial_port_pkg::ST_CMD:
        begin
          if (rise)
          begin
            next_st.in_shift = word_in; // see RULE7
            next_st.bit_cnt  = st.bit_cnt + 4'h1;
          end
          if (cmd_done)
          begin
            next_st.cmd_read = word_in[`CMD_READ_BIT]; // see RULE21
            next_st.cmd_inc  = word_in[`CMD_INC_BIT];
            next_st.addr     = word_in[`CMD_ADDR_MSB:0];
            next_st.mem_addr = word_in[`CMD_ADDR_MSB:0];
            next_st.rd_req   = word_in[`CMD_READ_BIT];
            next_st.rd_drive = word_in[`CMD_READ_BIT]; // see RULE22
            next_st.last_cmd = word_in;
            next_st.gap_cnt  = 8'h00;
            next_st.state    = serial_port_pkg::ST_DATA; // see RULE5
          end
        end
        serial_port_pkg::ST_DATA:
        begin
          // Shift read data out after falls inside the word, MSB first
          if (fall && st.rd_drive && st.bit_cnt != 4'h0)
            next_st.out_shift = {st.out_shift[14:0], 1'b0}; // see RULE22
          if (rise)
          begin
            if (st.bit_cnt == 4'h0 && st.gap_cnt < gap_need)
              next_st.gap_viol = 1'b1; // see RULE15
            next_st.in_shift = word_in;
            next_st.bit_cnt  = st.bit_cnt + 4'h1;
          end
          if (data_done)
          begin
            next_st.word_cnt = st.word_cnt + 16'h0001;
            next_st.gap_cnt  = 8'h00;
            if (!st.cmd_read)
            begin
              next_st.wr_req   = 1'b1; // see RULE13
              next_st.wr_data  = word_in;
              next_st.mem_addr = st.addr;
            end
            if (st.cmd_inc)
            begin
              next_st.addr = st.addr + 12'h001; // see RULE9
              if (st.cmd_read)
              begin
                next_st.rd_req   = 1'b1; // see RULE10
                next_st.mem_addr = st.addr + 12'h001;
              end
            end
            else
            begin
              next_st.state    = serial_port_pkg::ST_HOLD;
              next_st.rd_drive = 1'b0;
            end
          end
        end
        serial_port_pkg::ST_HOLD:
          next_st.state = serial_port_pkg::ST_HOLD;
      endcase
    end
  end

  // State register; reset clears every field of the port state
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '0; // see RULE20
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Loop-through is combinational so a chained device sees the bit at once
  assign serial_out = st.rd_drive ? st.out_shift[15] : serial_in; // see RULE3
  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_loop_through: assert property ( // see RULE12
    @(posedge clk_sys) disable iff (!reset_n)
    !st.rd_drive |-> serial_out == serial_in)
    else $error("serial_out does not follow serial_in");

  chk_read_drive: assert property ( // see RULE22
    @(posedge clk_sys) disable iff (!reset_n)
    st.rd_drive |-> serial_out == st.out_shift[15] && st.cmd_read)
    else $error("read phase not driving shift register");

  chk_strap_parks: assert property ( // see RULE2
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && strap_s |=> st.state == serial_port_pkg::ST_IDLE && !st.rd_drive)
    else $error("port active while strap high");

  chk_bit_sampled: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && rise && !cs_n_s && !strap_s && st.state == serial_port_pkg::ST_CMD
    |=> st.in_shift[0] == $past(sin_s) && st.bit_cnt == $past(st.bit_cnt) + 4'h1)
    else $error("command bit not sampled on rise");

  chk_cmd_fields: assert property ( // see RULE21
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && cmd_done && !cs_n_s && !strap_s
    |=> st.addr == $past(word_in[11:0]) && st.cmd_read == $past(word_in[15])
        && st.cmd_inc == $past(word_in[12]) && st.state == serial_port_pkg::ST_DATA)
    else $error("command word decoded wrongly");

  chk_auto_inc: assert property ( // see RULE9
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && data_done && st.cmd_inc && !cs_n_s && !strap_s
    |=> st.addr == $past(st.addr) + 12'h001 && st.state == serial_port_pkg::ST_DATA)
    else $error("address not incremented");

  chk_single_word: assert property ( // see RULE8
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && data_done && !st.cmd_inc && !cs_n_s && !strap_s
    |=> st.state == serial_port_pkg::ST_HOLD ##1 !st.wr_req)
    else $error("second word accepted without increment");

  chk_read_fetch: assert property ( // see RULE10
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && data_done && st.cmd_inc && st.cmd_read && !cs_n_s && !strap_s
    |=> st.rd_req && st.mem_addr == st.addr)
    else $error("next read word not fetched");

  chk_write_commit: assert property ( // see RULE13
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && data_done && !st.cmd_read && !cs_n_s && !strap_s
    |=> st.wr_req && st.wr_data == $past(word_in) && st.mem_addr == $past(st.addr))
    else $error("write word not committed");

  chk_apb_answer: assert property (
    @(posedge clk_sys) disable iff (!reset_n)
    clk_en && apb_access |=> pready ##1 !pready)
    else $error("APB answer not one cycle pulse");
endmodule

/* File: serial_port_regs.svh */
// Offsets, field positions, reset values and timing figures of the serial host port
`ifndef SERIAL_PORT_REGS_SVH
`define SERIAL_PORT_REGS_SVH

// APB register byte offsets
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_LAST_CMD    12'h008
`define OFS_WORD_COUNT  12'h00c

// Control register fields
`define CTRL_ANC_READBACK 0
`define CTRL_ANC_INSERT   1
`define CTRL_RESET        2'h0

// Status register fields
`define STAT_BUSY       0
`define STAT_TEST_MODE  1
`define STAT_GAP_VIOL   2
`define STAT_READ_DRIVE 3

// Command word layout
`define CMD_READ_BIT 15
`define CMD_INC_BIT  12
`define CMD_ADDR_MSB 11

// Timing figures in picoseconds
`define CLK_PERIOD_PS 4000
`define WR_GAP_PS     37100
`define RD_GAP_PS     148400
`define ANC_RD_GAP_PS 222600

`endif

/* File: serial_port_pkg.sv */
// Types shared by the serial host port modules
package serial_port_pkg;

  // Serial access sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA, ST_HOLD} port_state_t;

  // Complete state of the port top level
  typedef struct packed {
    port_state_t  state;
    logic [3:0]   bit_cnt;
    logic [15:0]  in_shift;
    logic [15:0]  out_shift;
    logic         cmd_read;
    logic         cmd_inc;
    logic [11:0]  addr;
    logic [11:0]  mem_addr;
    logic         sclk_prev;
    logic         rd_req;
    logic         wr_req;
    logic         load_pending;
    logic         rd_drive;
    logic [15:0]  wr_data;
    logic [7:0]   gap_cnt;
    logic         anc_readback;
    logic         anc_insert;
    logic         gap_viol;
    logic [15:0]  last_cmd;
    logic [15:0]  word_cnt;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } port_regs_t;

endpackage

/* File: reg_store_if.sv */
// Request and answer signals between the serial sequencer and the register store
`timescale 1ns/100ps
interface reg_store_if;
  logic        rd_en;
  logic        wr_en;
  logic [11:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  // Sequencer side
  modport engine (output rd_en, output wr_en, output addr, output wdata, input rdata);
  // Store side
  modport store (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

/* File: bit_sync.sv */
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t st;
  sync_t next_st;

  if (WIDTH < 1)
  begin : g_chk
    $error("bit_sync WIDTH must be at least 1");
  end

  // First stage is read only by the second stage
  always_comb
  begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign sync_out = st.s2;
endmodule

/* File: reg_store.sv */
// Word store for the configuration and status registers behind the serial port
`timescale 1ns/100ps
module reg_store #(
  parameter int DEPTH = 64
) (
  input  wire logic  clk_sys,
  input  wire logic  reset_n,
  input  wire logic  clk_en,
  reg_store_if.store bus
);

  localparam int          AW    = $clog2(DEPTH);
  localparam logic [12:0] LIMIT = 13'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][15:0] words;
    logic [15:0]            rdata;
  } store_t;

  store_t st;
  store_t next_st;
  logic   in_range;

  if (DEPTH < 2 || DEPTH > 4096 || (1 << AW) != DEPTH)
  begin : g_chk
    $error("reg_store DEPTH must be a power of two from 2 to 4096");
  end

  // Addresses beyond the store ignore writes and read as zero
  always_comb
  begin
    in_range = ({1'b0, bus.addr} < LIMIT);
    next_st  = st;
    if (bus.wr_en && in_range)
      next_st.words[bus.addr[AW-1:0]] = bus.wdata;
    if (bus.rd_en)
      next_st.rdata = in_range ? st.words[bus.addr[AW-1:0]] : 16'h0000;
  end

  // Reset clears every word
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  assign bus.rdata = st.rdata;
endmodule

/* File: serial_host_model.sv */
// Behavioural host that drives the chained serial register bus
`timescale 1ns/100ps
module serial_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  int          echo_err;
  logic [15:0] words [4];

  // Pins rest high as with the pull-ups, clock stands still low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b1;
    echo_err = 0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One word MSB first, data set up half a period before the rise
  task automatic shift(input logic [15:0] w, input logic echo, output logic [15:0] r);
    for (int i = 15; i >= 0; i--)
    begin
      serial_in = w[i];
      #1;
      if (echo && serial_out !== serial_in) echo_err++;
      #39 sclk = 1'b1;
      r[i] = serial_out;
      #40 sclk = 1'b0;
    end
  endtask

  // Whole access: select, command, data words, release
  task automatic access(input logic rd, input logic inc, input logic [11:0] a,
                        input int n, input int gap);
    logic [15:0] r;
    #1.3 cs_n = 1'b0;
    #40;
    shift({rd, 2'b00, inc, a}, 1'b1, r);
    for (int k = 0; k < n; k++)
    begin
      #(gap);
      shift(rd ? 16'hffff : words[k], !rd, r);
      if (rd) words[k] = r;
    end
    #40 cs_n = 1'b1;
    serial_in = 1'b1;
    #40; // Deselect long enough for the port to park before the next access
  endtask
endmodule

/* File: serial_host_register_port_test.sv */
// Self-checking bench for the serial host register port
`timescale 1ns/100ps
module serial_host_register_port_test;
  logic        clk_sys;
  logic        reset_n;
  logic        clk_en;
  logic        if_select;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        cs_n;
  logic        serial_in;
  logic        serial_out;
  int          fail_count;
  int          check_count;

  serial_host_register_port #(.DEPTH(64)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out), .if_select(if_select),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  serial_host_model host (
    .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out)
  );

  // Core clock, 4 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      fail_count++;
      $display("[ERR] pready expected 1 seen timeout");
      stop_test();
    end
    else
    begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic        er;
    apb(1'b0, a, 32'h0, d, er);
    chk(nm, e, d);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        er;
    apb(1'b1, a, v, d, er);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped address
  task automatic t_reset();
    logic [31:0] d;
    logic        er;
    rdc(12'h000, 32'h0, "ctrl");
    rdc(12'h004, 32'h0, "status");
    rdc(12'h008, 32'h0, "last_cmd");
    rdc(12'h00c, 32'h0, "word_count");
    apb(1'b0, 12'h010, 32'h0, d, er);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("unmapped_data", 32'h0, d);
    $display("t_reset done");
  endtask

  // Single write, loop-through, counters, read back
  task automatic t_single();
    host.words[0] = 16'ha5c3;
    host.access(1'b0, 1'b0, 12'h02a, 1, 0);
    chk("echo", 32'h0, host.echo_err);
    rdc(12'h008, 32'h002a, "last_cmd");
    rdc(12'h00c, 32'h1, "word_count");
    wr(12'h00c, 32'h0);
    rdc(12'h00c, 32'h0, "word_clear");
    host.access(1'b1, 1'b0, 12'h02a, 1, 120);
    chk("rdata", 32'ha5c3, {16'h0, host.words[0]});
    rdc(12'h004, 32'h0, "status_ok");
    $display("t_single done");
  endtask

  // Auto-increment write and read across the end of the store
  task automatic t_inc();
    host.words = '{16'h1357, 16'h2468, 16'h9abc, 16'hdef0};
    host.access(1'b0, 1'b1, 12'h03e, 4, 0);
    host.access(1'b1, 1'b1, 12'h03e, 4, 120);
    chk("inc0", 32'h1357, {16'h0, host.words[0]});
    chk("inc1", 32'h2468, {16'h0, host.words[1]});
    chk("inc2", 32'h0, {16'h0, host.words[2]});
    chk("inc3", 32'h0, {16'h0, host.words[3]});
    rdc(12'h008, 32'h903e, "last_cmd");
    $display("t_inc done");
  endtask

  // Read gaps too short, plain and with ancillary readback
  task automatic t_gap();
    host.access(1'b1, 1'b0, 12'h02a, 1, 0);
    rdc(12'h004, 32'h4, "gap_plain");
    wr(12'h004, 32'h4);
    rdc(12'h004, 32'h0, "gap_clear");
    wr(12'h000, 32'h3);
    rdc(12'h000, 32'h3, "ctrl");
    host.access(1'b1, 1'b0, 12'h02a, 1, 120);
    rdc(12'h004, 32'h4, "gap_anc");
    wr(12'h004, 32'h4);
    host.access(1'b1, 1'b0, 12'h02a, 1, 200);
    rdc(12'h004, 32'h0, "gap_anc_ok");
    wr(12'h000, 32'h0);
    $display("t_gap done");
  endtask

  // Strap high parks the port
  task automatic t_strap();
    @(posedge clk_sys);
    if_select <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rdc(12'h004, 32'h2, "test_mode");
    host.words[0] = 16'h7e81;
    host.access(1'b0, 1'b0, 12'h007, 1, 0);
    @(posedge clk_sys);
    if_select <= 1'b0;
    repeat (6) @(posedge clk_sys);
    host.access(1'b1, 1'b0, 12'h007, 1, 120);
    chk("parked", 32'h0, {16'h0, host.words[0]});
    $display("t_strap done");
  endtask

  // Main sequence
  initial
  begin
    fail_count = 0;
    check_count = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    if_select = 1'b0;
    paddr = 12'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset();
    t_single();
    t_inc();
    t_gap();
    t_strap();
    stop_test();
  end
endmodule
